// ---- src/fsg_start_guard.sv ----
// fsg_start_guard: frequent-start guard for a motor protection relay.
// assumes start flag, thermal level and settings are synchronous to core_clk_i.
//
// Notes on behaviour
// - hot-motor safe stall time setting, 0.1 s steps, default 15.0 s.
// - allowed starts per period for a cold motor, default 3.
// - allowed starts per period for a hot motor, default 2.
// - period in whole hours over which the start counts apply, default 1 h.
// - minimum gap between starts, 0.1 s steps, default 20.0 s.
// - alarm is on while exactly one start remains and no minimum gap is running.
// - inhibit is on once no starts remain, until one is available again.
// - blocked output is on when enabled but the block input is active.
// - each change of alarm, inhibit, blocked gives a stamped ON or OFF event.
// - per-event selection decides which events reach the main event buffer.
// - every operation lands in a ring of the twelve newest records.
// - a record holds stamp, event, inhibit duration, time since start, starts used.
// - each start adds the stall time; the counter decays by allowed starts per period.
// - motor counts as hot above a thermal limit, default 70 %; hot settings then apply.
// - cold-motor safe stall time setting, default 20.0 s.
module fsg_start_guard
   import fsg_pkg::*;
#(
   parameter int unsigned MS_DIV = MS_CYC
) (
   input  wire logic               core_clk_i,
   input  wire logic               reset_i,
   input  wire logic               enable_i,
   input  wire logic               block_i,
   input  wire logic               motor_start_flag_i,
   input  wire logic [PM_W-1:0]    thermal_pm_i,
   input  wire logic [STAMP_W-1:0] time_stamp_i,
   input  wire logic               cfg_load_i,
   input  wire logic [TS_W-1:0]    cfg_stall_hot_i,
   input  wire logic [TS_W-1:0]    cfg_stall_cold_i,
   input  wire logic [CNT_W-1:0]   cfg_starts_cold_i,
   input  wire logic [CNT_W-1:0]   cfg_starts_hot_i,
   input  wire logic [CNT_W-1:0]   cfg_period_h_i,
   input  wire logic [TS_W-1:0]    cfg_min_gap_i,
   input  wire logic [PM_W-1:0]    cfg_hot_limit_i,
   input  wire logic [N_EV-1:0]    event_sel_i,
   input  wire logic [3:0]         rec_age_i,
   output logic                    alarm_o,
   output logic                    inhibit_o,
   output logic                    blocked_o,
   output logic                    hot_o,
   output logic [STR_W-1:0]        stress_o,
   output logic [USED_W-1:0]       starts_used_o,
   output logic                    event_valid_o,
   output logic [EV_W-1:0]         event_code_o,
   output logic [STAMP_W-1:0]      event_stamp_o,
   output logic [STAMP_W-1:0]      rec_stamp_o,
   output logic [EV_W-1:0]         rec_event_o,
   output logic [DUR_W-1:0]        rec_inhibit_time_o,
   output logic [DUR_W-1:0]        rec_since_start_o,
   output logic [USED_W-1:0]       rec_starts_used_o,
   output logic [3:0]              rec_fill_o
);
   // ----------------------------------------
   // parameter checks
   // ----------------------------------------
   // the tick divider needs two clocks per program cycle at least
   if (MS_DIV < 2) begin : g_bad_div
      $error("fsg_start_guard: MS_DIV must be at least 2");
   end
   // stall time times allowed starts must fit the stress counter
   if (STR_W < TS_W + CNT_W) begin : g_bad_str
      $error("fsg_start_guard: stress counter too narrow");
   end

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [DUR_W-1:0] sat_inc(input logic [DUR_W-1:0] v);
      sat_inc = (&v) ? v : v + 20'h1;
   endfunction

   function automatic logic [EV_W-1:0] first_set(input logic [N_EV-1:0] v);
      first_set = '0;
      for (int i = N_EV - 1; i >= 0; i--) begin
         if (v[i]) begin
            first_set = EV_W'(i);
         end
      end
   endfunction

   // ----------------------------------------
   // time base
   // ----------------------------------------
   // program tick and 0.1 s tick share one divider so they never drift apart
   logic ms_tick;
   logic ds_tick;

   fsg_tick #(
      .MS_DIV (MS_DIV)
   ) u_tick (
      .core_clk_i (core_clk_i),
      .reset_i    (reset_i),
      .ms_tick_o  (ms_tick),
      .ds_tick_o  (ds_tick)
   );

   // ----------------------------------------
   // held settings
   // ----------------------------------------
   logic [TS_W-1:0]  stall_hot_r;
   logic [TS_W-1:0]  stall_cold_r;
   logic [CNT_W-1:0] starts_cold_r;
   logic [CNT_W-1:0] starts_hot_r;
   logic [CNT_W-1:0] period_h_r;
   logic [TS_W-1:0]  min_gap_r;
   logic [PM_W-1:0]  hot_limit_r;

   // a load takes every field at once so a half-written set is never used;
   // out-of-range values are taken as given, the setting front end checks ranges
   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         stall_hot_r   <= STALL_HOT_DEF;
         stall_cold_r  <= STALL_COLD_DEF;
         starts_cold_r <= STARTS_COLD_DEF;
         starts_hot_r  <= STARTS_HOT_DEF;
         period_h_r    <= PERIOD_H_DEF;
         min_gap_r     <= MIN_GAP_DEF;
         hot_limit_r   <= HOT_LIM_DEF;
      end else if (cfg_load_i) begin
         stall_hot_r   <= cfg_stall_hot_i;
         stall_cold_r  <= cfg_stall_cold_i;
         starts_cold_r <= cfg_starts_cold_i;
         starts_hot_r  <= cfg_starts_hot_i;
         period_h_r    <= cfg_period_h_i;
         min_gap_r     <= cfg_min_gap_i;
         hot_limit_r   <= cfg_hot_limit_i;
      end
   end

   // ----------------------------------------
   // hot/cold selection and limits
   // ----------------------------------------
   // hot/cold is re-evaluated every cycle, so a cooling motor returns to
   // the cold rate at once
   wire             is_hot   = thermal_pm_i > hot_limit_r;
   wire [TS_W-1:0]  stall    = is_hot ? stall_hot_r : stall_cold_r;
   wire [CNT_W-1:0] n_allow  = is_hot ? starts_hot_r : starts_cold_r;
   wire [STR_W-1:0] limit    = STR_W'(stall) * STR_W'(n_allow);
   wire [ACC_W-1:0] period   = ACC_W'(period_h_r) * ACC_W'(DS_PER_H);
   wire [STR_W:0]   one_more = {1'b0, stress_o} + (STR_W+1)'(stall);
   wire [STR_W+1:0] two_more = {2'b0, stress_o} + (STR_W+2)'({stall, 1'b0});
   // a start still fits while the counter has room for one more stall time
   wire             none_left = one_more > {1'b0, limit};
   wire             one_left  = !none_left && (two_more > {2'b0, limit});

   // ----------------------------------------
   // start detection and stress counter
   // ----------------------------------------
   logic             start_d_r;
   logic [ACC_W-1:0] acc_r;
   logic [DUR_W-1:0] since_start_r;
   logic             gap_run_r;

   wire running   = enable_i && !block_i;
   wire start_evt = running && ms_tick && motor_start_flag_i && !start_d_r;
   wire acc_full  = acc_r >= period;
   wire [STR_W:0] bumped = {1'b0, stress_o} + (STR_W+1)'(stall);
   wire [STR_W-1:0] bumped_sat = bumped[STR_W] ? '1 : bumped[STR_W-1:0];
   // decay feeds in once per 0.1 s and drains one count per clock,
   // so several counts per step are possible without a divider
   wire [ACC_W-1:0] acc_add = ds_tick ? ACC_W'(limit) : '0;

   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         start_d_r     <= 1'b0;
         stress_o      <= '0;
         acc_r         <= '0;
         starts_used_o <= '0;
         hot_o         <= 1'b0;
      end else begin
         hot_o <= is_hot;
         if (ms_tick) begin
            start_d_r <= motor_start_flag_i;
         end
         if (start_evt) begin
            stress_o      <= bumped_sat;
            starts_used_o <= (&starts_used_o) ? starts_used_o : starts_used_o + 8'h1;
         end else if (stress_o == '0) begin
            acc_r         <= '0;
            starts_used_o <= '0;
         end else if (acc_full) begin
            stress_o <= stress_o - 20'h1;
            acc_r    <= acc_r - period + acc_add;
         end else begin
            acc_r <= acc_r + acc_add;
         end
      end
   end

   // ----------------------------------------
   // elapsed times
   // ----------------------------------------
   logic [DUR_W-1:0] inhib_time_r;

   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         since_start_r <= '1;
         gap_run_r     <= 1'b0;
         inhib_time_r  <= '0;
      end else begin
         if (start_evt) begin
            since_start_r <= '0;
            gap_run_r     <= 1'b1;
         end else if (ds_tick) begin
            since_start_r <= sat_inc(since_start_r);
            if (since_start_r + 20'h1 >= DUR_W'(min_gap_r)) begin
               gap_run_r <= 1'b0;
            end
         end
         if (!inhibit_o) begin
            inhib_time_r <= '0;
         end else if (ds_tick) begin
            inhib_time_r <= sat_inc(inhib_time_r);
         end
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   // blocked or disabled forces alarm and inhibit low; the counter keeps decaying
   wire alarm_nxt   = running && one_left && !gap_run_r;
   wire inhibit_nxt = running && (none_left || gap_run_r);
   wire blocked_nxt = enable_i && block_i;

   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         alarm_o     <= 1'b0;
         inhibit_o   <= 1'b0;
         blocked_o   <= 1'b0;
      end else begin
         alarm_o     <= alarm_nxt;
         inhibit_o   <= inhibit_nxt;
         blocked_o   <= blocked_nxt;
      end
   end

   // ----------------------------------------
   // events
   // ----------------------------------------
   logic [N_EV-1:0] pend_r;

   // each output change sets one pending bit; the bit index is the event code
   wire alarm_rise = !alarm_o && alarm_nxt;
   wire alarm_fall = alarm_o && !alarm_nxt;
   wire inhib_rise = !inhibit_o && inhibit_nxt;
   wire inhib_fall = inhibit_o && !inhibit_nxt;
   wire block_rise = !blocked_o && blocked_nxt;
   wire block_fall = blocked_o && !blocked_nxt;
   wire [N_EV-1:0] edges = {block_fall, block_rise, inhib_fall, inhib_rise, alarm_fall, alarm_rise};
   wire [EV_W-1:0] ev_pick = first_set(pend_r);
   wire            ev_go   = |pend_r;
   wire [N_EV-1:0] ev_clr  = ev_go ? (N_EV'(1) << ev_pick) : '0;

   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         pend_r        <= '0;
         event_valid_o <= 1'b0;
         event_code_o  <= '0;
         event_stamp_o <= '0;
      end else begin
         // a new edge of a pending kind wins over its clear
         pend_r        <= (pend_r & ~ev_clr) | edges;
         event_valid_o <= ev_go && event_sel_i[ev_pick];
         event_code_o  <= ev_pick;
         event_stamp_o <= time_stamp_i;
      end
   end

   // ----------------------------------------
   // operation records
   // ----------------------------------------
   // every emitted event is logged, whatever the buffer selection says
   logic [REC_W-1:0] rec_data;

   wire [REC_W-1:0] rec_in = {time_stamp_i, ev_pick, inhib_time_r,
                              since_start_r, starts_used_o};

   fsg_rec_log #(
      .DEPTH (REC_DEPTH),
      .W     (REC_W)
   ) u_log (
      .core_clk_i (core_clk_i),
      .reset_i    (reset_i),
      .wr_i       (ev_go),
      .wr_data_i  (rec_in),
      .rd_age_i   (rec_age_i),
      .rd_data_o  (rec_data),
      .fill_o     (rec_fill_o)
   );

   assign {rec_stamp_o, rec_event_o, rec_inhibit_time_o,
           rec_since_start_o, rec_starts_used_o} = rec_data;
endmodule

// ---- src/fsg_pkg.sv ----
// fsg_pkg: constants shared by the frequent-start guard and its helpers.
// assumes a single 50 MHz core clock; settings arrive as plain ports.
package fsg_pkg;
   // ----------------------------------------
   // clock and time base
   // ----------------------------------------
   localparam int unsigned CLK_HZ      = 50_000_000;
   localparam int unsigned PROG_CYC_MS = 1;                           // program cycle, ms
   localparam int unsigned MS_CYC      = CLK_HZ / 1000 * PROG_CYC_MS; // clocks per program cycle
   localparam int unsigned DS_MS       = 100;                         // one 0.1 s step in ms
   localparam int unsigned DS_PER_H    = 36000;                       // 0.1 s steps per hour

   // ----------------------------------------
   // widths
   // ----------------------------------------
   localparam int unsigned TS_W   = 13;   // 0.1 s settings up to 600.0 s
   localparam int unsigned CNT_W  = 7;    // starts and hours up to 100
   localparam int unsigned PM_W   = 10;   // thermal capacity in 0.1 %
   localparam int unsigned STR_W  = 20;   // start-stress counter, 0.1 s
   localparam int unsigned ACC_W  = 24;   // decay accumulator
   localparam int unsigned DUR_W  = 20;   // elapsed times, 0.1 s
   localparam int unsigned STAMP_W = 48;  // time stamp, ms
   localparam int unsigned USED_W = 8;
   localparam int unsigned EV_W   = 3;

   // ----------------------------------------
   // setting defaults
   // ----------------------------------------
   localparam logic [TS_W-1:0]  STALL_HOT_DEF   = 13'h096;  // 15.0 s
   localparam logic [TS_W-1:0]  STALL_COLD_DEF  = 13'h0c8;  // 20.0 s
   localparam logic [CNT_W-1:0] STARTS_COLD_DEF = 7'h03;
   localparam logic [CNT_W-1:0] STARTS_HOT_DEF  = 7'h02;
   localparam logic [CNT_W-1:0] PERIOD_H_DEF    = 7'h01;
   localparam logic [TS_W-1:0]  MIN_GAP_DEF     = 13'h0c8;  // 20.0 s
   localparam logic [PM_W-1:0]  HOT_LIM_DEF     = 10'h2bc;  // 70.0 %

   // ----------------------------------------
   // events and operation records
   // ----------------------------------------
   localparam int unsigned N_EV      = 6;
   localparam int unsigned REC_DEPTH = 12;
   localparam int unsigned REC_W     = STAMP_W + EV_W + 2 * DUR_W + USED_W;
   // bit 2k = ON, bit 2k+1 = OFF for k = alarm, inhibit, blocked
   localparam logic [EV_W-1:0] EV_ALARM_ON   = 3'h0;
   localparam logic [EV_W-1:0] EV_ALARM_OFF  = 3'h1;
   localparam logic [EV_W-1:0] EV_INHIB_ON   = 3'h2;
   localparam logic [EV_W-1:0] EV_INHIB_OFF  = 3'h3;
   localparam logic [EV_W-1:0] EV_BLOCK_ON   = 3'h4;
   localparam logic [EV_W-1:0] EV_BLOCK_OFF  = 3'h5;
endpackage

// ---- src/fsg_tick.sv ----
// fsg_tick: divides the core clock into program-cycle and 0.1 s enables.
// assumes one clock; the enables are one-cycle pulses.
module fsg_tick
   import fsg_pkg::*;
#(
   parameter int unsigned MS_DIV = MS_CYC
) (
   input  wire logic core_clk_i,
   input  wire logic reset_i,
   output logic      ms_tick_o,
   output logic      ds_tick_o
);
   if (MS_DIV < 2) begin : g_bad_div
      $error("fsg_tick: MS_DIV must be at least 2");
   end

   logic [31:0] div_r;
   logic [7:0]  ms_r;
   wire         div_end = (div_r == MS_DIV - 1);
   wire         ms_end  = (ms_r == 8'(DS_MS - 1));

   // ----------------------------------------
   // dividers
   // ----------------------------------------
   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         div_r     <= '0;
         ms_r      <= '0;
         ms_tick_o <= 1'b0;
         ds_tick_o <= 1'b0;
      end else begin
         div_r     <= div_end ? '0 : div_r + 32'h1;
         ms_tick_o <= div_end;
         ds_tick_o <= div_end && ms_end;
         if (div_end) begin
            ms_r <= ms_end ? '0 : ms_r + 8'h1;
         end
      end
   end
endmodule

// ---- src/fsg_rec_log.sv ----
// fsg_rec_log: circular store of the most recent operation records.
// assumes one write per clock at most; read is by age, 0 = newest.
module fsg_rec_log
   import fsg_pkg::*;
#(
   parameter int unsigned DEPTH = REC_DEPTH,
   parameter int unsigned W     = REC_W
) (
   input  wire logic         core_clk_i,
   input  wire logic         reset_i,
   input  wire logic         wr_i,
   input  wire logic [W-1:0] wr_data_i,
   input  wire logic [3:0]   rd_age_i,
   output logic [W-1:0]      rd_data_o,
   output logic [3:0]        fill_o
);
   if (DEPTH < 2 || DEPTH > 15) begin : g_bad_depth
      $error("fsg_rec_log: DEPTH must be 2..15");
   end

   logic [W-1:0] mem_r [DEPTH];
   logic [3:0]   head_r;   // next slot to write
   // oldest entry is overwritten once the ring is full
   wire  [3:0]   last_slot = 4'(DEPTH - 1);
   wire  [4:0]   back      = {1'b0, head_r} + 5'(DEPTH) - 5'd1 - {1'b0, rd_age_i};
   wire  [3:0]   rd_slot   = (back >= 5'(DEPTH)) ? 4'(back - 5'(DEPTH)) : back[3:0];
   wire          rd_ok     = rd_age_i < fill_o;

   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         head_r    <= '0;
         fill_o    <= '0;
         rd_data_o <= '0;
      end else begin
         if (wr_i) begin
            head_r <= (head_r == last_slot) ? '0 : head_r + 4'h1;
            if (fill_o != 4'(DEPTH)) begin
               fill_o <= fill_o + 4'h1;
            end
         end
         rd_data_o <= rd_ok ? mem_r[rd_slot] : '0;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (wr_i) begin
         mem_r[head_r] <= wr_data_i;
      end
   end
endmodule

// ---- dv/fsg_start_guard_sva.sv ----
// fsg_start_guard_sva: port-level checks of the frequent-start guard.
// assumes it is bound to fsg_start_guard and sees its ports only.
module fsg_start_guard_sva
   import fsg_pkg::*;
(
   input wire logic              core_clk_i,
   input wire logic              reset_i,
   input wire logic              enable_i,
   input wire logic              block_i,
   input wire logic [N_EV-1:0]   event_sel_i,
   input wire logic              alarm_o,
   input wire logic              inhibit_o,
   input wire logic              blocked_o,
   input wire logic [STR_W-1:0]  stress_o,
   input wire logic [USED_W-1:0] starts_used_o,
   input wire logic              event_valid_o,
   input wire logic [EV_W-1:0]   event_code_o,
   input wire logic [3:0]        rec_fill_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [N_EV-1:0] sel_r;
   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         sel_r <= '0;
      end else begin
         sel_r <= event_sel_i;
      end
   end
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (reset_i);
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   blocked_lvl_a: assert property (!$past(reset_i) |-> blocked_o == $past(enable_i && block_i))
      else $error("blocked output does not follow enable and block");
   block_quiet_a: assert property (blocked_o |-> !alarm_o && !inhibit_o)
      else $error("alarm or inhibit while blocked");
   alarm_excl_a: assert property (!(alarm_o && inhibit_o))
      else $error("alarm and inhibit together");
   start_gap_a: assert property (!$past(reset_i) && starts_used_o == $past(starts_used_o) + 8'h01
      && enable_i && !block_i |=> inhibit_o)
      else $error("no inhibit after a start");
   stress_add_a: assert property (!$past(reset_i) && stress_o > $past(stress_o)
      |-> starts_used_o == $past(starts_used_o) + 8'h01)
      else $error("stress grew without a start");
   block_on_ev_a: assert property ($rose(blocked_o) && event_sel_i[4]
      |-> ##[1:8] event_valid_o && event_code_o == EV_BLOCK_ON)
      else $error("no blocked on event");
   block_off_ev_a: assert property ($fell(blocked_o) && event_sel_i[5]
      |-> ##[1:8] event_valid_o && event_code_o == EV_BLOCK_OFF)
      else $error("no blocked off event");
   ev_sel_a: assert property (event_valid_o |-> sel_r[event_code_o])
      else $error("unselected event emitted");
   rec_fill_a: assert property (rec_fill_o <= 4'hc
      && (!$changed(rec_fill_o) || rec_fill_o == $past(rec_fill_o) + 4'h1))
      else $error("record fill out of step");
   c_start: cover property (stress_o > $past(stress_o));
   c_alarm: cover property ($rose(alarm_o));
   c_inhib: cover property ($rose(inhibit_o));
   c_event: cover property (event_valid_o);
endmodule

bind fsg_start_guard fsg_start_guard_sva u_sva (.*);

// ---- dv/fsg_motor_model.sv ----
// fsg_motor_model: motor status and thermal side feeding the guard.
// assumes requests from the bench change at the falling edge.
module fsg_motor_model
   import fsg_pkg::*;
(
   input  wire logic       core_clk_i,
   input  wire logic       start_req_i,
   input  wire logic [7:0] hold_len_i,
   input  wire logic       hot_req_i,
   output logic            motor_start_flag_o,
   output logic [PM_W-1:0] thermal_pm_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] hold_r = 8'h00;
   // flag stays up over several program ticks, else the guard may miss it
   always @(posedge core_clk_i) begin
      hold_r <= start_req_i ? hold_len_i : (hold_r != 8'h00 ? hold_r - 8'h01 : 8'h00);
   end
   always @(negedge core_clk_i) begin
      motor_start_flag_o <= hold_r != 8'h00;
      thermal_pm_o <= hot_req_i ? 10'h320 : 10'h0c8;
   end
endmodule

// ---- dv/fsg_start_guard_tb_top.sv ----
// fsg_start_guard_tb_top: self-checking bench for the start guard.
// assumes a 1 ms tick of 10 clocks so the gap and decay stay short.
module fsg_start_guard_tb_top
   import fsg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [TS_W-1:0]  ST_C = 13'h004;
   localparam logic [CNT_W-1:0] N_C  = 7'h03;
   logic core_clk_i = 1'b0, reset_i = 1'b1, enable_i = 1'b0, block_i = 1'b0, cfg_load_i = 1'b0;
   logic start_req = 1'b0, hot_req = 1'b0, motor_start_flag_i, event_valid_o, alarm_o, inhibit_o;
   logic blocked_o, hot_o;
   logic [7:0]         hold_len = 8'h14;
   logic [PM_W-1:0]    thermal_pm_i;
   logic [STAMP_W-1:0] time_stamp_i = '0, event_stamp_o, rec_stamp_o;
   logic [N_EV-1:0]    event_sel_i = 6'h3f;
   logic [3:0]         rec_age_i = 4'h0, rec_fill_o;
   logic [STR_W-1:0]   stress_o;
   logic [USED_W-1:0]  starts_used_o, rec_starts_used_o;
   logic [EV_W-1:0]    event_code_o, rec_event_o, last_code;
   logic [STAMP_W-1:0] last_stamp = '0;
   logic [DUR_W-1:0]   rec_inhibit_time_o, rec_since_start_o;
   wire  [TS_W-1:0]    cfg_stall_hot_i = 13'h003, cfg_stall_cold_i = ST_C, cfg_min_gap_i = 13'h002;
   wire  [CNT_W-1:0]   cfg_starts_cold_i = N_C, cfg_starts_hot_i = 7'h02, cfg_period_h_i = PERIOD_H_DEF;
   wire  [PM_W-1:0]    cfg_hot_limit_i = HOT_LIM_DEF;
   integer seed = 86483, error_cnt = 0, tests_run = 0, ev_cnt = 0;

   fsg_start_guard #(.MS_DIV(10)) dut (.*);
   fsg_motor_model u_motor (.core_clk_i(core_clk_i), .start_req_i(start_req), .hold_len_i(hold_len),
      .hot_req_i(hot_req), .motor_start_flag_o(motor_start_flag_i), .thermal_pm_o(thermal_pm_i));

   always #10 core_clk_i = ~core_clk_i;
   always @(negedge core_clk_i) time_stamp_i <= {16'($random(seed)), 32'($random(seed))};
   // looked at mid-cycle, where the event outputs stand settled
   always @(negedge core_clk_i) begin
      if (event_valid_o === 1'b1) begin
         ev_cnt++;
         last_code = event_code_o;
         last_stamp = event_stamp_o;
         chk_val("event_stamp", time_stamp_i, event_stamp_o);
      end
   end

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic exp_alarm(input int n);
      return (ST_C * n + 2 * ST_C > ST_C * N_C) && (ST_C * n + ST_C <= ST_C * N_C);
   endfunction
   task automatic chk_val(input string name, input logic [STAMP_W-1:0] exp, input logic [STAMP_W-1:0] got);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
      end
   endtask
   task automatic chk_bit(input string name, input logic exp, input logic got);
      chk_val(name, {{(STAMP_W-1){1'b0}}, exp}, {{(STAMP_W-1){1'b0}}, got});
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge core_clk_i);
   endtask
   task automatic start_motor();
      hold_len = 8'h14 + {2'h0, 6'($random(seed))};
      start_req = 1'b1;
      idle(1);
      start_req = 1'b0;
      idle(120);
   endtask
   task automatic toggle_block();
      block_i = 1'b1;
      idle(60);
      block_i = 1'b0;
      idle(60);
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      idle(20);
      reset_i = 1'b0;
      idle(2);
      chk_val("stress", 0, stress_o);
      enable_i = 1'b1;
      cfg_load_i = 1'b1;
      idle(1);
      cfg_load_i = 1'b0;
      block_i = 1'b1;
      start_motor();
      chk_bit("blocked", 1'b1, blocked_o);
      chk_val("stress", 0, stress_o);
      chk_val("rec_event", EV_BLOCK_ON, rec_event_o);
      block_i = 1'b0;
      idle(60);
      chk_val("event", EV_BLOCK_OFF, last_code);
      for (int i = 1; i <= 3; i++) begin
         start_motor();
         chk_val("stress", ST_C * i, stress_o);
         chk_val("used", i, starts_used_o);
         chk_bit("inhibit", 1'b1, inhibit_o);
         chk_val("rec_event", EV_INHIB_ON, rec_event_o);
         chk_val("rec_used", i, rec_starts_used_o);
         chk_val("rec_stamp", last_stamp, rec_stamp_o);
         chk_bit("rec_since", 1'b1, rec_since_start_o < 20'h2);
         chk_bit("rec_inhib", 1'b1, rec_inhibit_time_o < 20'h2);
         for (int n = 0; n < 3000 && inhibit_o === 1'b1; n++) idle(1);
         chk_bit("inhibit", i == 3, inhibit_o);
         chk_bit("alarm", exp_alarm(i), alarm_o);
      end
      hot_req = 1'b1;
      idle(60);
      chk_bit("hot", 1'b1, hot_o);
      chk_bit("inhibit", 1'b1, inhibit_o);
      hot_req = 1'b0;
      repeat (3) toggle_block();
      chk_val("fill", ev_cnt > 12 ? 12 : ev_cnt, rec_fill_o);
      event_sel_i = 6'h20;
      ev_cnt = 0;
      toggle_block();
      chk_val("sel_cnt", 1, ev_cnt);
      chk_val("sel_code", EV_BLOCK_OFF, last_code);
      reset_i = 1'b1;
      idle(3);
      reset_i = 1'b0;
      idle(2);
      chk_val("fill", 0, rec_fill_o);
      end_of_test();
   end

   initial begin
      #(60_000 * 20);
      error_cnt++;
      end_of_test();
   end
endmodule
